// >>> pkg/timing_pkg.sv
package timing_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SPR_W = 10;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_WDATA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RDATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DIV = 8'h18;
  // special register numbers: arbitrary values
  localparam logic [SPR_W-1:0] SPR_TICK_WR_LO = 10'h210;
  localparam logic [SPR_W-1:0] SPR_TICK_WR_HI = 10'h211;
  localparam logic [SPR_W-1:0] SPR_TICK_RD_LO = 10'h10C;
  localparam logic [SPR_W-1:0] SPR_TICK_RD_HI = 10'h10D;
  localparam logic [SPR_W-1:0] SPR_DOWN = 10'h012;
  localparam logic [SPR_W-1:0] SPR_LEGACY_LO = 10'h005;
  localparam logic [SPR_W-1:0] SPR_LEGACY_HI = 10'h004;
  localparam int SPR_TOP = 9;
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_ILLEGAL = 2'h1;
  localparam logic [1:0] EXC_PRIV = 2'h2;
  localparam int IRQ_W = 2;
  localparam int ST_DOWN = 0;
  localparam int ST_PROG = 1;
  localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_WORD = 32'h0000_0001;
  localparam logic [DATA_W-1:0] DIV_RESET = 32'h0000_0000;
  localparam int CMD_W = 13;
  typedef struct packed {
    logic dedicated_read;
    logic supervisor;
    logic move_to;
    logic [SPR_W-1:0] special_reg_number;
  } op_cmd_t;
  typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage : timing_pkg

// >>> src/time_base_and_decrementer.sv
`timescale 1ns/100ps
// Operation
// - a 64-bit tick counter advances once per tick, frequency set by divider
// - lower half wrapping past all ones adds one to the upper half
// - counter written by move-to operation, read only by dedicated read operation
// - every bit of both counter halves is a real flip-flop
// - legacy clock register numbers are invalid and raise an exception
// - the down counter decrements on every tick that advances the counter
// - every bit of the down counter is a real flip-flop
// - down counter exception has its own request line, apart from others
// - down counter may be read only in supervisor state
// - a 10-bit special register number is decoded for every move operation
// - undefined number, user state, top bit set: privileged program exception only
// - undefined number otherwise: illegal program exception, nothing else altered
module time_base_and_decrementer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timing_pkg::ADDR_W-1:0] paddr,
  input wire logic [timing_pkg::DATA_W-1:0] pwdata,
  output logic [timing_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic down_vector_req,
  output logic program_vector_req
);
  function automatic logic spr_known(input logic [timing_pkg::SPR_W-1:0] n);
    spr_known = (n == timing_pkg::SPR_TICK_WR_LO) || (n == timing_pkg::SPR_TICK_WR_HI)
      || (n == timing_pkg::SPR_DOWN);
  endfunction : spr_known

  function automatic logic [1:0] op_exc(input timing_pkg::op_cmd_t c);
    logic [1:0] e;
    e = timing_pkg::EXC_NONE;
    if (c.dedicated_read)
    begin
      if (c.special_reg_number != timing_pkg::SPR_TICK_RD_LO && c.special_reg_number != timing_pkg::SPR_TICK_RD_HI)
        e = timing_pkg::EXC_ILLEGAL;
    end
    else if (!spr_known(c.special_reg_number))
      // privileged flavour chosen wherever both answers are allowed
      e = (!c.supervisor && c.special_reg_number[timing_pkg::SPR_TOP]) ? timing_pkg::EXC_PRIV
        : timing_pkg::EXC_ILLEGAL;
    else if (c.special_reg_number != timing_pkg::SPR_DOWN && !c.move_to)
      e = timing_pkg::EXC_ILLEGAL;
    else if (!c.supervisor)
      e = timing_pkg::EXC_PRIV;
    op_exc = e;
  endfunction : op_exc

  timing_pkg::bus_state_t state_reg;
  logic [timing_pkg::DATA_W-1:0] wdata_reg, op_rdata_reg, div_reg, div_cnt_reg;
  logic [timing_pkg::DATA_W-1:0] tick_counter_lower, tick_counter_upper, down_counter;
  logic [1:0] result_reg;
  logic [timing_pkg::IRQ_W-1:0] status_reg, status_next, mask_reg, status_set, status_clr;
  logic access, first, done, mapped, op_go, op_ok, tick;
  logic wr_lo, wr_hi, wr_down, down_evt;
  logic [1:0] exc;
  timing_pkg::op_cmd_t cmd;
  logic [timing_pkg::DATA_W-1:0] read_mux;

  assign access = psel && penable;
  assign first = access && (state_reg == timing_pkg::BUS_IDLE);
  assign done = access && (state_reg == timing_pkg::BUS_ANSWER);
  assign mapped = (paddr == timing_pkg::OFF_CMD) || (paddr == timing_pkg::OFF_WDATA)
    || (paddr == timing_pkg::OFF_RDATA) || (paddr == timing_pkg::OFF_RESULT)
    || (paddr == timing_pkg::OFF_STATUS) || (paddr == timing_pkg::OFF_MASK)
    || (paddr == timing_pkg::OFF_DIV);
  assign cmd = timing_pkg::op_cmd_t'(pwdata[timing_pkg::CMD_W-1:0]);
  assign op_go = done && pwrite && (paddr == timing_pkg::OFF_CMD);
  assign exc = op_exc(cmd);
  assign op_ok = op_go && (exc == timing_pkg::EXC_NONE);
  assign wr_lo = op_ok && !cmd.dedicated_read && (cmd.special_reg_number == timing_pkg::SPR_TICK_WR_LO);
  assign wr_hi = op_ok && !cmd.dedicated_read && (cmd.special_reg_number == timing_pkg::SPR_TICK_WR_HI);
  assign wr_down = op_ok && !cmd.dedicated_read && cmd.move_to
    && (cmd.special_reg_number == timing_pkg::SPR_DOWN);
  assign tick = (div_cnt_reg >= div_reg);
  assign down_evt = tick && !wr_down && (down_counter == timing_pkg::ZERO_WORD);

  always_comb
  begin
    read_mux = timing_pkg::ZERO_WORD;
    case (paddr)
      timing_pkg::OFF_WDATA: read_mux = wdata_reg;
      timing_pkg::OFF_RDATA: read_mux = op_rdata_reg;
      timing_pkg::OFF_RESULT: read_mux = {30'h0000_0000, result_reg};
      timing_pkg::OFF_STATUS: read_mux = {30'h0000_0000, status_reg};
      timing_pkg::OFF_MASK: read_mux = {30'h0000_0000, mask_reg};
      timing_pkg::OFF_DIV: read_mux = div_reg;
      default: read_mux = timing_pkg::ZERO_WORD;
    endcase
  end

  // one wait state: read data is ready before the completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= timing_pkg::BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= timing_pkg::ZERO_WORD;
    end
    else
    begin
      case (state_reg)
        timing_pkg::BUS_IDLE: if (first) state_reg <= timing_pkg::BUS_ANSWER;
        timing_pkg::BUS_ANSWER: state_reg <= timing_pkg::BUS_IDLE;
        default: state_reg <= timing_pkg::BUS_IDLE;
      endcase
      pready <= first;
      pslverr <= first && !mapped;
      prdata <= (first && !pwrite) ? read_mux : timing_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdata_reg <= timing_pkg::ZERO_WORD;
      mask_reg <= '0;
      div_reg <= timing_pkg::DIV_RESET;
    end
    else if (done && pwrite)
    begin
      if (paddr == timing_pkg::OFF_WDATA) wdata_reg <= pwdata;
      if (paddr == timing_pkg::OFF_MASK) mask_reg <= pwdata[timing_pkg::IRQ_W-1:0];
      if (paddr == timing_pkg::OFF_DIV) div_reg <= pwdata;
    end
  end

  // exceptions leave the read-back word untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_reg <= timing_pkg::EXC_NONE;
      op_rdata_reg <= timing_pkg::ZERO_WORD;
    end
    else if (op_go)
    begin
      result_reg <= exc;
      if (op_ok && cmd.dedicated_read)
        op_rdata_reg <= (cmd.special_reg_number == timing_pkg::SPR_TICK_RD_HI) ? tick_counter_upper
          : tick_counter_lower;
      else if (op_ok && !cmd.move_to)
        op_rdata_reg <= down_counter;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_reg <= timing_pkg::ZERO_WORD;
    else
      div_cnt_reg <= tick ? timing_pkg::ZERO_WORD : div_cnt_reg + timing_pkg::ONE_WORD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_counter_lower <= timing_pkg::ZERO_WORD;
      tick_counter_upper <= timing_pkg::ZERO_WORD;
    end
    else
    begin
      if (wr_lo)
        tick_counter_lower <= wdata_reg;
      else if (tick)
        tick_counter_lower <= tick_counter_lower + timing_pkg::ONE_WORD;
      if (wr_hi)
        tick_counter_upper <= wdata_reg;
      else if (tick && tick_counter_lower == timing_pkg::ALL_ONES)
        tick_counter_upper <= tick_counter_upper + timing_pkg::ONE_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      down_counter <= timing_pkg::ZERO_WORD;
    else if (wr_down)
      down_counter <= wdata_reg;
    else if (tick)
      down_counter <= down_counter - timing_pkg::ONE_WORD;
  end

  // set beats the read-clear; only bits already returned in prdata are cleared,
  // so an event landing between the data edge and the completing edge survives
  always_comb
  begin
    status_set = '0;
    status_set[timing_pkg::ST_DOWN] = down_evt;
    status_set[timing_pkg::ST_PROG] = op_go && (exc != timing_pkg::EXC_NONE);
    status_clr = (done && !pwrite && paddr == timing_pkg::OFF_STATUS)
      ? prdata[timing_pkg::IRQ_W-1:0] : '0;
    status_next = (status_reg & ~status_clr) | status_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= '0;
      irq <= 1'b0;
      down_vector_req <= 1'b0;
      program_vector_req <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
      down_vector_req <= status_next[timing_pkg::ST_DOWN] && mask_reg[timing_pkg::ST_DOWN];
      program_vector_req <= status_next[timing_pkg::ST_PROG] && mask_reg[timing_pkg::ST_PROG];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lower_count_a: assert property (tick && !wr_lo |=>
    tick_counter_lower == $past(tick_counter_lower) + timing_pkg::ONE_WORD)
    else $error("lower half did not count");
  upper_carry_a: assert property (tick && !wr_hi
    && tick_counter_lower == timing_pkg::ALL_ONES |=>
    tick_counter_upper == $past(tick_counter_upper) + timing_pkg::ONE_WORD)
    else $error("no carry into upper half");
  upper_hold_a: assert property (!wr_hi && !(tick
    && tick_counter_lower == timing_pkg::ALL_ONES) |=> $stable(tick_counter_upper))
    else $error("upper half moved without carry");
  down_step_a: assert property (tick && !wr_down |=>
    down_counter == $past(down_counter) - timing_pkg::ONE_WORD)
    else $error("down counter out of step");
  down_event_a: assert property (down_evt |=> status_reg[timing_pkg::ST_DOWN]
    && down_counter == timing_pkg::ALL_ONES)
    else $error("down counter event lost");
  down_vector_a: assert property (down_evt && mask_reg[timing_pkg::ST_DOWN]
    && $stable(mask_reg) |=> down_vector_req)
    else $error("down counter request missing");
  user_down_a: assert property (op_go && !cmd.dedicated_read && !cmd.supervisor
    && cmd.special_reg_number == timing_pkg::SPR_DOWN |=> result_reg == timing_pkg::EXC_PRIV
    && op_rdata_reg == $past(op_rdata_reg))
    else $error("user read of down counter allowed");
  legacy_bad_a: assert property (op_go && !cmd.dedicated_read
    && (cmd.special_reg_number == timing_pkg::SPR_LEGACY_LO || cmd.special_reg_number == timing_pkg::SPR_LEGACY_HI)
    |=> result_reg != timing_pkg::EXC_NONE ##1 status_reg[timing_pkg::ST_PROG])
    else $error("legacy number accepted");
  user_top_a: assert property (op_go && !cmd.dedicated_read && !spr_known(cmd.special_reg_number)
    && !cmd.supervisor && cmd.special_reg_number[timing_pkg::SPR_TOP] |=>
    result_reg == timing_pkg::EXC_PRIV && $stable(down_counter) == !$past(tick))
    else $error("user top bit case wrong");
  undef_other_a: assert property (op_go && !cmd.dedicated_read && !spr_known(cmd.special_reg_number)
    && (cmd.supervisor || !cmd.special_reg_number[timing_pkg::SPR_TOP]) |=>
    result_reg == timing_pkg::EXC_ILLEGAL && op_rdata_reg == $past(op_rdata_reg))
    else $error("undefined number case wrong");
  tick_read_a: assert property (op_go && !cmd.dedicated_read && !cmd.move_to
    && cmd.special_reg_number == timing_pkg::SPR_TICK_WR_LO |=> result_reg == timing_pkg::EXC_ILLEGAL)
    else $error("counter read by move-from");

  carry_seen_c: cover property (tick && tick_counter_lower == timing_pkg::ALL_ONES);
  down_wrap_c: cover property (down_evt ##1 down_vector_req);
  priv_exc_c: cover property (op_go && exc == timing_pkg::EXC_PRIV);
  tick_read_c: cover property (op_ok && cmd.dedicated_read);
endmodule : time_base_and_decrementer

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [timing_pkg::ADDR_W-1:0] paddr;
  logic [timing_pkg::DATA_W-1:0] pwdata;
  logic [timing_pkg::DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic down_vector_req;
  logic program_vector_req;
  logic [31:0] rd_data;
  logic rd_err;
  int mismatches;
  int check_count;
  int wait_n;
  logic [9:0] und_spr [7] = '{10'h3FF, 10'h0FF, 10'h3FF, timing_pkg::SPR_LEGACY_LO,
    timing_pkg::SPR_LEGACY_HI, timing_pkg::SPR_DOWN, timing_pkg::SPR_TICK_WR_LO};
  logic und_sup [7] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
  logic [1:0] und_exc [7] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1};

  time_base_and_decrementer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .down_vector_req(down_vector_req),
    .program_vector_req(program_vector_req));

  task finish_test;
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one idle cycle between transfers keeps each strobe edge distinct
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50)
      chk("pready", 32'h1, 32'h0);
  endtask : apb

  task op(input logic sup, input logic mt, input logic dr, input logic [9:0] special_reg_number,
          input logic [31:0] d);
    timing_pkg::op_cmd_t c;
    c.dedicated_read = dr;
    c.supervisor = sup;
    c.move_to = mt;
    c.special_reg_number = special_reg_number;
    if (mt)
      apb(1'h1, timing_pkg::OFF_WDATA, d);
    apb(1'h1, timing_pkg::OFF_CMD, {19'h0, c});
  endtask : op

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(name, exp, rd_data);
  endtask : rd_chk

  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end

  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk("result_rst", timing_pkg::OFF_RESULT, 32'h0);
    rd_chk("mask_rst", timing_pkg::OFF_MASK, 32'h0);
    rd_chk("div_rst", timing_pkg::OFF_DIV, 32'h0);
    op(1'h1, 1'h1, 1'h0, timing_pkg::SPR_TICK_WR_HI, 32'hDEAD_BEEF);
    op(1'h1, 1'h1, 1'h0, timing_pkg::SPR_TICK_WR_LO, 32'hFFFF_FF00);
    op(1'h0, 1'h0, 1'h1, timing_pkg::SPR_TICK_RD_HI, 32'h0);
    rd_chk("tick_hi", timing_pkg::OFF_RDATA, 32'hDEAD_BEEF);
    op(1'h0, 1'h0, 1'h1, timing_pkg::SPR_TICK_RD_LO, 32'h0);
    apb(1'h0, timing_pkg::OFF_RDATA, 32'h0);
    chk("tick_lo", 32'hFFFFFF, {8'h0, rd_data[31:8]});
    repeat (300) @(posedge pclk);
    op(1'h0, 1'h0, 1'h1, timing_pkg::SPR_TICK_RD_HI, 32'h0);
    rd_chk("tick_carry", timing_pkg::OFF_RDATA, 32'hDEAD_BEF0);
    apb(1'h1, timing_pkg::OFF_MASK, 32'h2);
    for (int i = 0; i < 7; i++)
    begin
      op(und_sup[i], 1'h0, 1'h0, und_spr[i], 32'h0);
      rd_chk("exc_code", timing_pkg::OFF_RESULT, {30'h0, und_exc[i]});
      rd_chk("rdata_kept", timing_pkg::OFF_RDATA, 32'hDEAD_BEF0);
    end
    chk("prog_vec", 32'h1, {31'h0, program_vector_req});
    chk("irq_prog", 32'h1, {31'h0, irq});
    apb(1'h1, timing_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'h0, timing_pkg::OFF_STATUS, 32'h0);
    chk("stat_prog", 32'h2, rd_data & 32'h2);
    rd_chk("stat_clr", timing_pkg::OFF_STATUS, 32'h0);
    op(1'h1, 1'h1, 1'h0, timing_pkg::SPR_DOWN, 32'hA5A5_A5A5);
    op(1'h1, 1'h0, 1'h0, timing_pkg::SPR_DOWN, 32'h0);
    apb(1'h0, timing_pkg::OFF_RDATA, 32'h0);
    chk("down_bits", 32'hA5A5A5, {8'h0, rd_data[31:8]});
    op(1'h1, 1'h1, 1'h0, timing_pkg::SPR_DOWN, 32'h14);
    apb(1'h1, timing_pkg::OFF_MASK, 32'h1);
    wait_n = 0;
    while (down_vector_req !== 1'h1 && wait_n < 60)
    begin
      @(posedge pclk);
      wait_n++;
    end
    // wrap lands about 18 edges after the mask write
    chk("down_wrap_time", 32'h1, {31'h0, wait_n >= 17 && wait_n <= 21});
    chk("irq_down", 32'h1, {31'h0, irq});
    rd_chk("stat_down", timing_pkg::OFF_STATUS, 32'h1);
    rd_chk("stat_clr2", timing_pkg::OFF_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_low", 32'h0, {31'h0, irq});
    op(1'h1, 1'h0, 1'h0, timing_pkg::SPR_DOWN, 32'h0);
    apb(1'h0, timing_pkg::OFF_RDATA, 32'h0);
    chk("down_after_wrap", 32'hFFFFFF, {8'h0, rd_data[31:8]});
    apb(1'h1, timing_pkg::OFF_DIV, 32'h3);
    rd_chk("div_rw", timing_pkg::OFF_DIV, 32'h3);
    chk("mapped_err", 32'h0, {31'h0, rd_err});
    op(1'h1, 1'h1, 1'h0, timing_pkg::SPR_DOWN, 32'h100);
    repeat (40) @(posedge pclk);
    op(1'h1, 1'h0, 1'h0, timing_pkg::SPR_DOWN, 32'h0);
    apb(1'h0, timing_pkg::OFF_RDATA, 32'h0);
    chk("down_rate", 32'h1, {31'h0, rd_data >= 32'hF0 && rd_data <= 32'hFA});
    apb(1'h0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rd_err});
    chk("unmapped_data", 32'h0, rd_data);
    finish_test();
  end
endmodule : tb
